// ===== pkg/pio_pkg.sv
// Constants for the parallel I/O port block: register map, widths, resets.
// Assumes a 16-bit register port with byte addresses on a 16-bit word grid.
package pio_pkg;

   // ==========================================================
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_PA_FUNC  = 8'h00;
   localparam logic [7:0] OFS_PA_DIR   = 8'h02;
   localparam logic [7:0] OFS_PA_DATA  = 8'h04;
   localparam logic [7:0] OFS_PB_FUNC  = 8'h06;
   localparam logic [7:0] OFS_PB_DIR   = 8'h08;
   localparam logic [7:0] OFS_PB_DATA  = 8'h0a;
   localparam logic [7:0] OFS_GLOBAL_INTERRUPT_MODE_REGISTER     = 8'h10;
   localparam logic [7:0] OFS_IMR      = 8'h12;

   // ==========================================================
   // Port widths and field positions
   localparam int PA_W       = 16;
   localparam int PB_W       = 12;
   localparam int PB_LO_W    = 8;
   localparam int PB_HI_LSB  = 8;
   localparam int PB_HI_W    = 4;
   localparam int WATCHDOG_OUTPUT_BIT   = 7;
   localparam int TIMER1_INPUT_BIT   = 3;
   localparam int TIMER2_INPUT_BIT   = 5;
   localparam int GLOBAL_INTERRUPT_MODE_REGISTER_EN_BIT = 0;

   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_PA_FUNC = 16'h0000;
   localparam logic [15:0] RST_PA_DIR  = 16'h0000;
   localparam logic [7:0]  RST_PB_FUNC = 8'h80;
   localparam logic [11:0] RST_PB_DIR  = 12'h000;
   localparam logic [15:0] RST_GLOBAL_INTERRUPT_MODE_REGISTER    = 16'h0000;
   localparam logic [3:0]  RST_IMR     = 4'h0;

   // ==========================================================
   // Dedicated port B low pins that the block drives (1 = output)
   localparam logic [7:0]  PB_DED_OE   = 8'hd7;

   // Priority index of each upper pin inside level 4 (3 = highest)
   localparam logic [1:0]  PRI_PB11 = 2'h3;
   localparam logic [1:0]  PRI_PB10 = 2'h2;
   localparam logic [1:0]  PRI_PB9  = 2'h1;
   localparam logic [1:0]  PRI_PB8  = 2'h0;

endpackage

// ===== rtl/parallel_port.sv
// Parallel I/O ports A and B with port B upper-pin falling-edge requests.
// Assumes pins arrive asynchronously and registers sit on a simple
// strobe port whose read data appears one cycle after the read strobe.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

module parallel_port
   import pio_pkg::*;
#(
   parameter logic [15:0] PA_TIE = 16'h8000
)
(
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic [pio_pkg::ADDR_W-1:0]   addr,
   input  wire logic [pio_pkg::DATA_W-1:0]   wdata,
   input  wire logic                         wr,
   input  wire logic                         rd,
   output logic      [pio_pkg::DATA_W-1:0]   rdata,
   input  wire logic [pio_pkg::PA_W-1:0]     pa_in,
   output logic      [pio_pkg::PA_W-1:0]     pa_out,
   output logic      [pio_pkg::PA_W-1:0]     pa_oe,
   input  wire logic [pio_pkg::PA_W-1:0]     pa_ded_out,
   input  wire logic [pio_pkg::PA_W-1:0]     pa_ded_oe,
   output logic      [pio_pkg::PA_W-1:0]     pa_ded_in,
   input  wire logic [pio_pkg::PB_W-1:0]     pb_in,
   output logic      [pio_pkg::PB_W-1:0]     pb_out,
   output logic      [pio_pkg::PB_W-1:0]     pb_oe,
   input  wire logic                         level7_acknowledge_out,
   input  wire logic                         level6_acknowledge_out,
   input  wire logic                         level1_acknowledge_out,
   input  wire logic                         timer1_output,
   input  wire logic                         timer2_output,
   input  wire logic                         watchdog_output,
   output logic                              timer1_input,
   output logic                              timer2_input,
   output logic      [pio_pkg::PB_HI_W-1:0]  pb_irq_req,
   output logic      [1:0]                   pb_irq_pri
);
   import pio_pkg::*;

   // ==========================================================
   // Helpers

   // Pin drive value and enable for one port
   function automatic logic [15:0] pin_drive(input logic [15:0] func,
                                             input logic [15:0] lat,
                                             input logic [15:0] dout);
      pin_drive = (func & dout) | (~func & lat);
   endfunction

   function automatic logic [15:0] pin_enable(input logic [15:0] func,
                                              input logic [15:0] dir,
                                              input logic [15:0] doe);
      pin_enable = (func & doe) | (~func & dir);
   endfunction

   // Data register read view: drive value for driven pins, pin for sensed ones
   function automatic logic [15:0] data_view(input logic [15:0] oe,
                                             input logic [15:0] drv,
                                             input logic [15:0] pin);
      data_view = (oe & drv) | (~oe & pin);
   endfunction

   // ==========================================================
   // Registers and internal signals
   logic [15:0] pa_func_q;
   logic [15:0] pa_dir_q;
   logic [15:0] pa_lat_q;
   logic [7:0]  pb_func_q;
   logic [11:0] pb_dir_q;
   logic [11:0] pb_lat_q;
   logic [15:0] global_interrupt_mode_register_q;
   logic [3:0]  imr_q;
   logic [15:0] rdata_q;
   logic [15:0] pa_s1_q;
   logic [15:0] pa_s2_q;
   logic [11:0] pb_s1_q;
   logic [11:0] pb_s2_q;
   logic [3:0]  pb_hi_prev_q;
   logic [15:0] pb_func_ext;
   logic [15:0] pb_dir_ext;
   logic [15:0] pb_lat_ext;
   logic [15:0] pb_dout_ext;
   logic [15:0] pb_doe_ext;
   logic [15:0] pb_drv;
   logic [15:0] pb_en;
   logic [15:0] pa_drv;
   logic [15:0] pa_en;
   logic [3:0]  hi_fall;
   logic [15:0] rd_val;

   // ==========================================================
   // Pin synchronisers, two flops each
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pa_s1_q <= 16'h0000;
         pa_s2_q <= 16'h0000;
         pb_s1_q <= 12'h000;
         pb_s2_q <= 12'h000;
      end
      else
      begin
         pa_s1_q <= pa_in;
         pa_s2_q <= pa_s1_q;
         pb_s1_q <= pb_in;
         pb_s2_q <= pb_s1_q;
      end
   end

   // ==========================================================
   // Configuration registers; reset makes pins general inputs, except PB7 which drives watchdog_output
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pa_func_q <= RST_PA_FUNC;
         pa_dir_q  <= RST_PA_DIR;
         pb_func_q <= RST_PB_FUNC;
         pb_dir_q  <= RST_PB_DIR;
         global_interrupt_mode_register_q    <= RST_GLOBAL_INTERRUPT_MODE_REGISTER;
         imr_q     <= RST_IMR;
      end
      else if (wr)
      begin
         case (addr)
            OFS_PA_FUNC: pa_func_q <= wdata;
            OFS_PA_DIR:  pa_dir_q  <= wdata;
            OFS_PB_FUNC: pb_func_q <= wdata[7:0];
            OFS_PB_DIR:  pb_dir_q  <= wdata[11:0];
            OFS_GLOBAL_INTERRUPT_MODE_REGISTER:    global_interrupt_mode_register_q    <= wdata;
            OFS_IMR:     imr_q     <= wdata[3:0];
            default:     ;
         endcase
      end
   end

   // Output latches; written whatever the pin direction
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pa_lat_q <= 16'h0000;
         pb_lat_q <= 12'h000;
      end
      else if (wr && addr == OFS_PA_DATA)
         pa_lat_q <= wdata;
      else if (wr && addr == OFS_PB_DATA)
         pb_lat_q <= wdata[11:0];
   end

   // ==========================================================
   // Port B views widened to 16 bits; upper pins never dedicated
   assign pb_func_ext = {8'h00, pb_func_q};
   assign pb_dir_ext  = {4'h0, pb_dir_q};
   assign pb_lat_ext  = {4'h0, pb_lat_q};
   assign pb_dout_ext = {8'h00, watchdog_output, timer2_output, 1'b0, timer1_output,
                         1'b0, level1_acknowledge_out, level6_acknowledge_out,
                         level7_acknowledge_out};
   assign pb_doe_ext  = {8'h00, PB_DED_OE};

   // Pin multiplexers: dedicated function overrides direction
   assign pa_drv = pin_drive(pa_func_q, pa_lat_q, pa_ded_out);
   assign pa_en  = pin_enable(pa_func_q, pa_dir_q, pa_ded_oe);
   assign pb_drv = pin_drive(pb_func_ext, pb_lat_ext, pb_dout_ext);
   assign pb_en  = pin_enable(pb_func_ext, pb_dir_ext, pb_doe_ext);
   assign pa_out = pa_drv & pa_en;
   assign pa_oe  = pa_en;
   assign pb_out = pb_drv[11:0] & pb_en[11:0];
   assign pb_oe  = pb_en[11:0];

   // Peripheral inputs; general-use pins feed a constant
   assign pa_ded_in    = (pa_func_q & pa_s2_q) | (~pa_func_q & PA_TIE);
   assign timer1_input = pb_func_q[TIMER1_INPUT_BIT] & pb_s2_q[TIMER1_INPUT_BIT];
   assign timer2_input = pb_func_q[TIMER2_INPUT_BIT] & pb_s2_q[TIMER2_INPUT_BIT];

   // ==========================================================
   // Upper pin falling-edge requests
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pb_hi_prev_q <= 4'h0;
      else
         pb_hi_prev_q <= pb_s2_q[11:8];
   end

   // Edge only on input pins, gated by mode and mask
   assign hi_fall    = pb_hi_prev_q & ~pb_s2_q[11:8] & ~pb_dir_q[11:8];
   assign pb_irq_req = hi_fall & imr_q & {4{global_interrupt_mode_register_q[GLOBAL_INTERRUPT_MODE_REGISTER_EN_BIT]}};

   // Fixed priority of the highest active request
   always_comb
   begin
      if (pb_irq_req[3])
         pb_irq_pri = PRI_PB11;
      else if (pb_irq_req[2])
         pb_irq_pri = PRI_PB10;
      else if (pb_irq_req[1])
         pb_irq_pri = PRI_PB9;
      else
         pb_irq_pri = PRI_PB8;
   end

   // ==========================================================
   // Register read path
   always_comb
   begin
      case (addr)
         OFS_PA_FUNC: rd_val = pa_func_q;
         OFS_PA_DIR:  rd_val = pa_dir_q;
         OFS_PA_DATA: rd_val = data_view(pa_en, pa_drv, pa_s2_q);
         OFS_PB_FUNC: rd_val = pb_func_ext;
         OFS_PB_DIR:  rd_val = pb_dir_ext;
         OFS_PB_DATA: rd_val = data_view(pb_en, pb_drv, {4'h0, pb_s2_q}) & 16'h0fff;
         OFS_GLOBAL_INTERRUPT_MODE_REGISTER:    rd_val = global_interrupt_mode_register_q;
         OFS_IMR:     rd_val = {12'h000, imr_q};
         default:     rd_val = 16'h0000;
      endcase
   end

   // Read data stands one cycle only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 16'h0000;
      else if (rd)
         rdata_q <= rd_val;
      else
         rdata_q <= 16'h0000;
   end

   assign rdata = rdata_q;

   // ==========================================================
   // Checks
   AST_WATCHDOG_OUTPUT_AFTER_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> pb_func_q[WATCHDOG_OUTPUT_BIT] && pb_dir_q[11:8] == 4'h0)
      else $error("watchdog bit or upper direction wrong after reset");

   AST_GLOBAL_INTERRUPT_MODE_REGISTER_AFTER_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> global_interrupt_mode_register_q == 16'h0000 && pb_irq_req == 4'h0)
      else $error("mode register not clear after reset");

   AST_FALL_RAISES_REQ: assert property (@(posedge clk) disable iff (!rst_n)
      (pb_s2_q[8] && !pb_dir_q[8] && imr_q[0] && global_interrupt_mode_register_q[GLOBAL_INTERRUPT_MODE_REGISTER_EN_BIT]) ##1
      (!pb_s2_q[8] && !pb_dir_q[8] && imr_q[0] && global_interrupt_mode_register_q[GLOBAL_INTERRUPT_MODE_REGISTER_EN_BIT]) |-> pb_irq_req[0])
      else $error("falling edge on input pin gave no request");

   AST_ONE_REQ_PER_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
      pb_irq_req[1] |=> !pb_irq_req[1])
      else $error("request held longer than one cycle");

   AST_OUTPUT_NO_REQ: assert property (@(posedge clk) disable iff (!rst_n)
      pb_dir_q[11:8] == 4'hf |-> pb_irq_req == 4'h0)
      else $error("request from output pin");

   AST_MASK_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
      !imr_q[3] |-> !pb_irq_req[3])
      else $error("masked request passed");

   AST_READ_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == OFS_PB_DATA && pb_dir_q[9] && !wr) |=> rdata[9] == $past(pb_lat_q[9]))
      else $error("output pin read not from latch");

   AST_READ_PIN: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == OFS_PB_DATA && !pb_dir_q[10]) |=> rdata[10] == $past(pb_s2_q[10]))
      else $error("input pin read not from pin");

   AST_PB_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && (addr == OFS_PB_FUNC || addr == OFS_PB_DIR)) |=> rdata[15:12] == 4'h0)
      else $error("unused port B bits read nonzero");

   AST_TIMER_GROUND: assert property (@(posedge clk) disable iff (!rst_n)
      !pb_func_q[TIMER1_INPUT_BIT] |-> !timer1_input ##1 (pb_func_q[TIMER1_INPUT_BIT] || !timer1_input))
      else $error("timer input not grounded in general use");

   AST_WATCHDOG_OUTPUT_PIN: assert property (@(posedge clk) disable iff (!rst_n)
      pb_func_q[WATCHDOG_OUTPUT_BIT] |-> pb_oe[7] && pb_out[7] == watchdog_output)
      else $error("watchdog pin not driven by timer");

   COV_EDGE_REQ:   cover property (@(posedge clk) disable iff (!rst_n) pb_irq_req != 4'h0);
   COV_TWO_REQ:    cover property (@(posedge clk) disable iff (!rst_n) &pb_irq_req[3:2]);
   COV_LATCH_READ: cover property (@(posedge clk) disable iff (!rst_n)
      rd && addr == OFS_PB_DATA && pb_dir_q[11]);

endmodule

// ===== tb/pin_model.sv
// Far-side model: pin wiring of ports A and B and the peripheral signals.
// Assumes the bench sets external pin levels and the peripheral pattern.
`timescale 1ns/100ps
module pin_model
   import pio_pkg::*;
(
   input  wire logic [pio_pkg::PA_W-1:0] pa_out,
   input  wire logic [pio_pkg::PA_W-1:0] pa_oe,
   input  wire logic [pio_pkg::PA_W-1:0] ext_a,
   output logic      [pio_pkg::PA_W-1:0] pa_in,
   input  wire logic [pio_pkg::PB_W-1:0] pb_out,
   input  wire logic [pio_pkg::PB_W-1:0] pb_oe,
   input  wire logic [pio_pkg::PB_W-1:0] ext_b,
   output logic      [pio_pkg::PB_W-1:0] pb_in,
   input  wire logic [5:0]               periph,
   output logic [5:0]                    ded_o
);
   // ==========================================================
   // Wire level: a driven pin shows the drive, else the outside level
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
   // Peripheral drives: {watchdog_output, timer2_output, timer1_output, ack1, ack6, ack7}
   assign ded_o = periph;
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the parallel port block.
// Assumes the pin model on the far side and a 10 MHz clock.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
   import pio_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, pa_out, pa_oe, pa_ded_in, pa_in, rv;
   logic [11:0] pb_in, pb_out, pb_oe, ext_b = 12'h000;
   logic [5:0]  periph = 6'h00, ded_o;
   logic [3:0]  pb_irq_req, irq_cnt = 4'h0;
   logic [1:0]  pb_irq_pri, last_pri = 2'h0;
   logic        timer1_input, timer2_input;
   int          err_total = 0, checks_done = 0, cyc = 0;
   parallel_port uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
      .pa_ded_out(16'h0000), .pa_ded_oe(16'h0000), .pa_ded_in(pa_ded_in),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .level7_acknowledge_out(ded_o[0]),
      .level6_acknowledge_out(ded_o[1]), .level1_acknowledge_out(ded_o[2]),
      .timer1_output(ded_o[3]), .timer2_output(ded_o[4]), .watchdog_output(ded_o[5]),
      .timer1_input(timer1_input), .timer2_input(timer2_input),
      .pb_irq_req(pb_irq_req), .pb_irq_pri(pb_irq_pri));
   pin_model far (.pa_out(pa_out), .pa_oe(pa_oe), .ext_a(16'h1234), .pa_in(pa_in),
      .pb_out(pb_out), .pb_oe(pb_oe), .ext_b(ext_b), .pb_in(pb_in),
      .periph(periph), .ded_o(ded_o));
   // ==========================================================
   // Clock, cycle ceiling and per-pin request pulse flags
   initial
   begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_total++;
         conclude();
      end
      for (int i = 0; i < 4; i++)
         if (pb_irq_req[i] === 1'b1)
         begin
            irq_cnt[i] <= 1'b1;
            last_pri <= pb_irq_pri;
         end
   end
   // ==========================================================
   // Bus tasks
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd_reg(OFS_PB_FUNC, rv); `CHK("pb_func", 16'h0080, rv)
      rd_reg(OFS_PB_DIR, rv);  `CHK("pb_dir", 16'h0000, rv)
      rd_reg(OFS_GLOBAL_INTERRUPT_MODE_REGISTER, rv);    `CHK("global_interrupt_mode_register", 16'h0000, rv)
      rd_reg(OFS_PA_FUNC, rv); `CHK("pa_func", 16'h0000, rv)
      rd_reg(8'h1e, rv);       `CHK("unmapped", 16'h0000, rv)
      `CHK("pb_oe", 12'h080, pb_oe)
      `CHK("pb7_drv", ded_o[5], pb_out[7])
   endtask
   task automatic t_dedicated;
      logic [7:0] drv;
      periph <= 6'h2d;
      ext_b <= 12'h008;
      wr_reg(OFS_PB_DIR, 16'h00ff);
      wr_reg(OFS_PB_FUNC, 16'hffff);
      wait_clk(3);
      drv = {ded_o[5], ded_o[4], 1'b0, ded_o[3], 1'b0, ded_o[2:0]};
      `CHK("ded_oe", PB_DED_OE, pb_oe[7:0])
      `CHK("ded_out", drv, pb_out[7:0] & PB_DED_OE)
      `CHK("timer1_input", 1'b1, timer1_input)
      `CHK("timer2_input", 1'b0, timer2_input)
      rd_reg(OFS_PB_DATA, rv); `CHK("ded_data", drv | 8'h08, rv[7:0])
      rd_reg(OFS_PB_FUNC, rv); `CHK("func_rb", 16'h00ff, rv)
      wr_reg(OFS_PB_FUNC, 16'h0000);
      wait_clk(1);
      `CHK("timer1_input_gnd", 1'b0, timer1_input)
      `CHK("gp_oe", 12'h0ff, pb_oe)
   endtask
   task automatic t_upper;
      ext_b <= 12'h500;
      wr_reg(OFS_PB_DATA, 16'hfa00);
      wr_reg(OFS_PB_DIR, 16'hff00);
      wait_clk(1);
      `CHK("hi_oe", 4'hf, pb_oe[11:8])
      `CHK("hi_out", 4'ha, pb_out[11:8])
      rd_reg(OFS_PB_DATA, rv); `CHK("hi_latch", 4'ha, rv[11:8])
      rd_reg(OFS_PB_DIR, rv);  `CHK("dir_rsv", 16'h0f00, rv)
      wr_reg(OFS_PB_DIR, 16'h0000);
      wait_clk(3);
      `CHK("hi_in_oe", 4'h0, pb_oe[11:8])
      rd_reg(OFS_PB_DATA, rv); `CHK("hi_pin", 16'h0500, rv)
   endtask
   task automatic t_edge(input int p, input logic [15:0] dir, input logic [15:0] global_interrupt_mode_register,
                         input logic [15:0] interrupt_mask_register, input logic [3:0] exp);
      wr_reg(OFS_PB_DIR, dir);
      wr_reg(OFS_GLOBAL_INTERRUPT_MODE_REGISTER, global_interrupt_mode_register);
      wr_reg(OFS_IMR, interrupt_mask_register);
      @(posedge clk) ext_b[p] <= 1'b1;
      wait_clk(5);
      irq_cnt <= 4'h0;
      @(posedge clk) ext_b[p] <= 1'b0;
      wait_clk(6);
      `CHK("irq", exp, irq_cnt)
   endtask
   task automatic t_porta;
      wr_reg(OFS_PA_DIR, 16'h00ff);
      wr_reg(OFS_PA_DATA, 16'habcd);
      wait_clk(3);
      `CHK("pa_oe", 16'h00ff, pa_oe)
      `CHK("pa_out", 16'h00cd, pa_out)
      `CHK("pa_tie", 16'h8000, pa_ded_in)
      rd_reg(OFS_PA_DATA, rv); `CHK("pa_data", 16'h12cd, rv)
      wr_reg(OFS_PA_FUNC, 16'h0004);
      wait_clk(1);
      `CHK("pa_ded_in", 16'h8004, pa_ded_in)
      `CHK("pa_ded_oe", 16'h00fb, pa_oe)
   endtask
   task automatic t_irq;
      t_edge(8, 16'h0000, 16'h0001, 16'h000f, 4'h1);
      `CHK("pri8", PRI_PB8, last_pri)
      t_edge(11, 16'h0000, 16'h0001, 16'h000f, 4'h8);
      `CHK("pri11", PRI_PB11, last_pri)
      t_edge(9, 16'h0000, 16'h0001, 16'h000d, 4'h0);
      t_edge(10, 16'h0000, 16'h0000, 16'h000f, 4'h0);
      t_edge(10, 16'h0400, 16'h0001, 16'h000f, 4'h0);
   endtask
   // ==========================================================
   // Verdict and main sequence
   task automatic conclude;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_dedicated();
      t_upper();
      t_porta();
      t_irq();
      conclude();
   end
endmodule
